//--- src/dcc_regs.svh
// Register map, field positions and reset values of the channel control block
`ifndef DCC_REGS_SVH
`define DCC_REGS_SVH

`define DCC_CTRLB_ADDR 32'h0FFFEC4C
`define DCC_CFG_ADDR 32'hFFFFEC50
`define DCC_SADDR_RD_ADDR 32'hFFFFEDF0
`define DCC_DADDR_RD_ADDR 32'hFFFFEDF4
`define DCC_STAT_ADDR 32'hFFFFEDF8

`define DCC_CTRLB_MASK 32'hF3711111
`define DCC_CFG_MASK 32'h377133FF
`define DCC_CTRLB_RESET 32'h00000000
`define DCC_CFG_RESET 32'h00000000

`define DCC_B_SRC_SEL 0
`define DCC_B_DST_SEL 4
`define DCC_B_SRC_WIN 8
`define DCC_B_DST_WIN 12
`define DCC_B_SRC_DOFF 16
`define DCC_B_DST_DOFF 20
`define DCC_B_DIR_HI 22
`define DCC_B_DIR_LO 21
`define DCC_B_SMODE_HI 25
`define DCC_B_SMODE_LO 24
`define DCC_B_DMODE_HI 29
`define DCC_B_DMODE_LO 28
`define DCC_B_FLAG_DIS_N 30
`define DCC_B_AUTO 31

`define DCC_C_SPER_HI 3
`define DCC_C_SPER_LO 0
`define DCC_C_DPER_HI 7
`define DCC_C_DPER_LO 4
`define DCC_C_SREP 8
`define DCC_C_SHS 9
`define DCC_C_DREP 12
`define DCC_C_DHS 13
`define DCC_C_STOP 16
`define DCC_C_IF_LOCK 20
`define DCC_C_BUS_LOCK 21
`define DCC_C_ARB_LVL 22
`define DCC_C_PROT_HI 26
`define DCC_C_PROT_LO 24
`define DCC_C_POL_HI 29
`define DCC_C_POL_LO 28

`define DCC_A_DONE 31
`define DCC_A_DW_HI 29
`define DCC_A_DW_LO 28
`define DCC_A_SW_HI 25
`define DCC_A_SW_LO 24

`define DCC_STEP_BYTE 32'h00000001
`define DCC_STEP_HALF 32'h00000002
`define DCC_STEP_WORD 32'h00000004

`endif

//--- src/dcc_pkg.sv
// Types shared by the channel control block
package dcc_pkg;
   typedef enum logic [1:0] {DCC_INC = 2'h0, DCC_DEC = 2'h1, DCC_FIX = 2'h2} dcc_amode_e;
   typedef enum logic [1:0] {DCC_ALAP = 2'h0, DCC_HALF = 2'h1, DCC_ASAP = 2'h2} dcc_policy_e;
   typedef enum logic [0:0] {DCC_IDLE = 1'h0, DCC_ACTIVE = 1'h1} dcc_state_e;
endpackage : dcc_pkg

//--- src/dcc_channel.sv
// Channel control and configuration logic of one DMA channel
//
// Register access is over APB, through the zero-wait-state slave below.
`timescale 1ns/1ps
`include "dcc_regs.svh"

module dcc_channel
   import dcc_pkg::*;
#(
   parameter int NPER = 16,
   parameter int LVL_W = 6,
   parameter int FIFO_DEPTH = 32
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic write_protection_on,
   input wire logic ch_start,
   input wire logic [31:0] start_saddr,
   input wire logic [31:0] start_daddr,
   input wire logic [31:0] start_ctrla,
   input wire logic desc_load,
   input wire logic [31:0] desc_saddr,
   input wire logic [31:0] desc_daddr,
   input wire logic [31:0] desc_ctrla,
   input wire logic src_beat,
   input wire logic dst_beat,
   input wire logic buffer_end,
   input wire logic chunk_active,
   input wire logic [9:0] spip_boundary,
   input wire logic [15:0] spip_hole,
   input wire logic [9:0] dpip_boundary,
   input wire logic [15:0] dpip_hole,
   input wire logic [NPER-1:0] hw_req,
   input wire logic sw_src_req,
   input wire logic sw_dst_req,
   input wire logic [LVL_W-1:0] fifo_level,
   input wire logic [LVL_W-1:0] burst_len,
   output logic channel_active,
   output logic [31:0] src_addr,
   output logic [31:0] dst_addr,
   output logic [31:0] ctrla_cur,
   output logic src_master_sel,
   output logic dst_master_sel,
   output logic src_is_periph,
   output logic dst_is_periph,
   output logic dmac_flow_ctrl,
   output logic src_req,
   output logic dst_req,
   output logic buffer_complete_flag,
   output logic desc_wb_req,
   output logic desc_wb_done,
   output logic auto_disable,
   output logic arb_hold,
   output logic if_lock,
   output logic bus_lock,
   output logic [2:0] bus_protection_attributes,
   output logic fifo_service
);

   logic [31:0] ctrlb_q;
   logic [31:0] cfg_q;
   logic [31:0] prdata_q;
   dcc_state_e state_q;
   logic [31:0] src_addr_q;
   logic [31:0] dst_addr_q;
   logic [31:0] src_base_q;
   logic [31:0] dst_base_q;
   logic [31:0] ctrla_q;
   logic [31:0] ctrla_base_q;
   logic [9:0] spip_cnt_q;
   logic [9:0] dpip_cnt_q;
   logic flag_q;
   logic wb_q;
   logic dis_q;
   logic wr_en;
   logic hit;
   logic src_bound;
   logic dst_bound;
   logic do_stop;
   logic auto_on;
   logic single_end;

   // Byte step from a two-bit transfer width field
   function automatic logic [31:0] step_of(input logic [1:0] w);
      logic [31:0] s;
      s = `DCC_STEP_WORD;
      if (w == 2'h0)
      begin
         s = `DCC_STEP_BYTE;
      end
      else if (w == 2'h1)
      begin
         s = `DCC_STEP_HALF;
      end
      return s;
   endfunction : step_of

   // Address after one beat: hole jump at a window boundary, else per mode
   function automatic logic [31:0] next_addr(input logic [31:0] a, input logic [1:0] mode,
                                             input logic [1:0] w, input logic jump,
                                             input logic [15:0] hole);
      logic [31:0] n;
      n = a;
      if (jump)
      begin
         n = a + {16'h0000, hole};
      end
      else if (mode == DCC_INC)
      begin
         n = a + step_of(w);
      end
      else if (mode == DCC_DEC)
      begin
         n = a - step_of(w);
      end
      return n;
   endfunction : next_addr

   // Window counter reaches the programmed boundary on this beat
   function automatic logic at_bound(input logic en, input logic [9:0] cnt, input logic [9:0] bnd);
      return en && (bnd != 10'h000) && ((cnt + 10'h001) == bnd);
   endfunction : at_bound

   // APB slave: zero wait states, read data latched in the setup phase
   assign pready = 1'b1;
   assign hit = (paddr == `DCC_CTRLB_ADDR) || (paddr == `DCC_CFG_ADDR) || (paddr == `DCC_SADDR_RD_ADDR)
                || (paddr == `DCC_DADDR_RD_ADDR) || (paddr == `DCC_STAT_ADDR);
   assign pslverr = psel && penable && !hit;
   assign wr_en = psel && penable && pwrite && !write_protection_on;
   assign prdata = prdata_q;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_q <= 32'h00000000;
      end
      else if (psel && !penable && !pwrite)
      begin
         unique case (paddr)
            `DCC_CTRLB_ADDR: prdata_q <= ctrlb_q;
            `DCC_CFG_ADDR: prdata_q <= cfg_q;
            `DCC_SADDR_RD_ADDR: prdata_q <= src_addr_q;
            `DCC_DADDR_RD_ADDR: prdata_q <= dst_addr_q;
            `DCC_STAT_ADDR: prdata_q <= {31'h00000000, state_q == DCC_ACTIVE};
            default: prdata_q <= 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrlb_q <= `DCC_CTRLB_RESET;
         cfg_q <= `DCC_CFG_RESET;
      end
      else if (wr_en)
      begin
         if (paddr == `DCC_CTRLB_ADDR)
         begin
            ctrlb_q <= pwdata & `DCC_CTRLB_MASK;
         end
         if (paddr == `DCC_CFG_ADDR)
         begin
            cfg_q <= pwdata & `DCC_CFG_MASK;
         end
      end
   end

   assign auto_on = ctrlb_q[`DCC_B_AUTO];
   assign do_stop = desc_load && cfg_q[`DCC_C_STOP] && desc_ctrla[`DCC_A_DONE];
   assign single_end = buffer_end && !auto_on && ctrlb_q[`DCC_B_SRC_DOFF] && ctrlb_q[`DCC_B_DST_DOFF];
   assign src_bound = src_beat && at_bound(ctrlb_q[`DCC_B_SRC_WIN], spip_cnt_q, spip_boundary);
   assign dst_bound = dst_beat && at_bound(ctrlb_q[`DCC_B_DST_WIN], dpip_cnt_q, dpip_boundary);

   // Channel run state
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q <= DCC_IDLE;
      end
      else
      begin
         unique case (state_q)
            DCC_IDLE:
            begin
               if (ch_start)
               begin
                  state_q <= DCC_ACTIVE;
               end
            end
            DCC_ACTIVE:
            begin
               if (do_stop || single_end)
               begin
                  state_q <= DCC_IDLE;
               end
            end
         endcase
      end
   end

   // Control A copy and replay base
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrla_q <= 32'h00000000;
         ctrla_base_q <= 32'h00000000;
      end
      else if (ch_start)
      begin
         ctrla_q <= start_ctrla;
         ctrla_base_q <= start_ctrla;
      end
      else if (desc_load)
      begin
         ctrla_q <= desc_ctrla;
         ctrla_base_q <= desc_ctrla;
      end
      else if (buffer_end && auto_on && (cfg_q[`DCC_C_SREP] || cfg_q[`DCC_C_DREP]))
      begin
         ctrla_q <= ctrla_base_q;
      end
   end

   // Source address
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         src_addr_q <= 32'h00000000;
         src_base_q <= 32'h00000000;
      end
      else if (ch_start)
      begin
         src_addr_q <= start_saddr;
         src_base_q <= start_saddr;
      end
      else if (desc_load && !ctrlb_q[`DCC_B_SRC_DOFF])
      begin
         src_addr_q <= desc_saddr;
         src_base_q <= desc_saddr;
      end
      else if (buffer_end && auto_on && cfg_q[`DCC_C_SREP])
      begin
         src_addr_q <= src_base_q;
      end
      else if (src_beat)
      begin
         src_addr_q <= next_addr(src_addr_q, ctrlb_q[`DCC_B_SMODE_HI:`DCC_B_SMODE_LO],
                                 ctrla_q[`DCC_A_SW_HI:`DCC_A_SW_LO], src_bound, spip_hole);
      end
   end

   // Destination address
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         dst_addr_q <= 32'h00000000;
         dst_base_q <= 32'h00000000;
      end
      else if (ch_start)
      begin
         dst_addr_q <= start_daddr;
         dst_base_q <= start_daddr;
      end
      else if (desc_load && !ctrlb_q[`DCC_B_DST_DOFF])
      begin
         dst_addr_q <= desc_daddr;
         dst_base_q <= desc_daddr;
      end
      else if (buffer_end && auto_on && cfg_q[`DCC_C_DREP])
      begin
         dst_addr_q <= dst_base_q;
      end
      else if (dst_beat)
      begin
         dst_addr_q <= next_addr(dst_addr_q, ctrlb_q[`DCC_B_DMODE_HI:`DCC_B_DMODE_LO],
                                 ctrla_q[`DCC_A_DW_HI:`DCC_A_DW_LO], dst_bound, dpip_hole);
      end
   end

   // Window counters restart on every load and at each boundary
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         spip_cnt_q <= 10'h000;
      end
      else if (ch_start || desc_load || buffer_end || src_bound)
      begin
         spip_cnt_q <= 10'h000;
      end
      else if (src_beat && ctrlb_q[`DCC_B_SRC_WIN])
      begin
         spip_cnt_q <= spip_cnt_q + 10'h001;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         dpip_cnt_q <= 10'h000;
      end
      else if (ch_start || desc_load || buffer_end || dst_bound)
      begin
         dpip_cnt_q <= 10'h000;
      end
      else if (dst_beat && ctrlb_q[`DCC_B_DST_WIN])
      begin
         dpip_cnt_q <= dpip_cnt_q + 10'h001;
      end
   end

   // Event pulses of buffer end and descriptor stop
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         flag_q <= 1'b0;
         wb_q <= 1'b0;
         dis_q <= 1'b0;
      end
      else
      begin
         flag_q <= buffer_end && !ctrlb_q[`DCC_B_FLAG_DIS_N];
         wb_q <= buffer_end;
         dis_q <= do_stop && (state_q == DCC_ACTIVE);
      end
   end

   assign channel_active = (state_q == DCC_ACTIVE);
   assign src_addr = src_addr_q;
   assign dst_addr = dst_addr_q;
   assign ctrla_cur = ctrla_q;
   assign buffer_complete_flag = flag_q;
   assign desc_wb_req = wb_q;
   assign desc_wb_done = wb_q;
   assign auto_disable = dis_q;
   assign src_master_sel = ctrlb_q[`DCC_B_SRC_SEL];
   assign dst_master_sel = ctrlb_q[`DCC_B_DST_SEL];
   assign src_is_periph = ctrlb_q[`DCC_B_DIR_HI];
   assign dst_is_periph = ctrlb_q[`DCC_B_DIR_LO];
   assign dmac_flow_ctrl = 1'b1;

   // Request sources: memory ends always ready, peripheral ends by handshake
   always_comb
   begin
      src_req = 1'b1;
      dst_req = 1'b1;
      if (src_is_periph)
      begin
         src_req = cfg_q[`DCC_C_SHS] ? hw_req[cfg_q[`DCC_C_SPER_HI:`DCC_C_SPER_LO]] : sw_src_req;
      end
      if (dst_is_periph)
      begin
         dst_req = cfg_q[`DCC_C_DHS] ? hw_req[cfg_q[`DCC_C_DPER_HI:`DCC_C_DPER_LO]] : sw_dst_req;
      end
   end

   assign if_lock = cfg_q[`DCC_C_IF_LOCK] && channel_active;
   assign bus_lock = cfg_q[`DCC_C_BUS_LOCK] && channel_active;
   assign arb_hold = if_lock && (cfg_q[`DCC_C_ARB_LVL] ? 1'b1 : chunk_active);
   assign bus_protection_attributes = cfg_q[`DCC_C_PROT_HI:`DCC_C_PROT_LO];

   always_comb
   begin
      unique case (cfg_q[`DCC_C_POL_HI:`DCC_C_POL_LO])
         DCC_ALAP: fifo_service = (fifo_level >= burst_len);
         DCC_HALF: fifo_service = ({{(32-LVL_W){1'b0}}, fifo_level} >= (FIFO_DEPTH / 2));
         default: fifo_service = (fifo_level != '0);
      endcase
   end

   stop_disable_a: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == DCC_ACTIVE) && desc_load && cfg_q[`DCC_C_STOP] && desc_ctrla[`DCC_A_DONE]
      |=> !channel_active && auto_disable) else $error("channel not stopped on done");
   stop_ignored_a: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == DCC_ACTIVE) && desc_load && !cfg_q[`DCC_C_STOP] && !single_end
      |=> channel_active) else $error("done flag not ignored");
   writeback_a: assert property (@(posedge pclk) disable iff (!presetn)
      buffer_end |=> desc_wb_req && desc_wb_done) else $error("done flag not written back");
   flag_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      buffer_complete_flag |-> $past(buffer_end) && !$past(ctrlb_q[`DCC_B_FLAG_DIS_N]))
      else $error("buffer flag misgated");
   protect_a: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && pwrite && write_protection_on |=> $stable(ctrlb_q) && $stable(cfg_q))
      else $error("protected write took effect");
   reserved_a: assert property (@(posedge pclk) disable iff (!presetn)
      ((ctrlb_q & ~`DCC_CTRLB_MASK) == 32'h0) && ((cfg_q & ~`DCC_CFG_MASK) == 32'h0))
      else $error("reserved bit set");
   src_fixed_a: assert property (@(posedge pclk) disable iff (!presetn)
      src_beat && !ch_start && !desc_load && !buffer_end && !src_bound
      && ctrlb_q[`DCC_B_SMODE_HI:`DCC_B_SMODE_LO] == DCC_FIX |=> $stable(src_addr))
      else $error("fixed source moved");
   dst_inc_a: assert property (@(posedge pclk) disable iff (!presetn)
      dst_beat && !ch_start && !desc_load && !buffer_end && !dst_bound
      && ctrlb_q[`DCC_B_DMODE_HI:`DCC_B_DMODE_LO] == DCC_INC
      |=> dst_addr == $past(dst_addr) + step_of($past(ctrla_q[`DCC_A_DW_HI:`DCC_A_DW_LO])))
      else $error("destination not incremented");
   src_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
      desc_load && !ch_start && ctrlb_q[`DCC_B_SRC_DOFF] && !src_beat |=> $stable(src_addr))
      else $error("fetch changed source");
   hw_req_a: assert property (@(posedge pclk) disable iff (!presetn)
      src_is_periph && cfg_q[`DCC_C_SHS] |-> src_req == hw_req[cfg_q[`DCC_C_SPER_HI:`DCC_C_SPER_LO]])
      else $error("source request misrouted");

endmodule : dcc_channel

//--- tb/dcc_periph_model.sv
// Peripheral side model that drives the hardware handshake request lines
`timescale 1ns/1ps
module dcc_periph_model
#(
   parameter int NPER = 16
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [NPER-1:0] want,
   output logic [NPER-1:0] hw_req
);
   // Request lines change only just after a clock edge
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         hw_req <= '0;
      end
      else
      begin
         hw_req <= want;
      end
   end
endmodule : dcc_periph_model

//--- tb/dcc_channel_tb_top.sv
// Self-checking testbench of the channel control block
`timescale 1ns/1ps
`include "dcc_regs.svh"
module dcc_channel_tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic wp = 1'b0;
   logic [31:0] paddr = 32'h00000000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic ch_start = 1'b0;
   logic desc_load = 1'b0;
   logic src_beat = 1'b0;
   logic dst_beat = 1'b0;
   logic buffer_end = 1'b0;
   logic [31:0] desc_ctrla = 32'h00000000;
   logic [9:0] spip_boundary = 10'h000;
   logic [15:0] spip_hole = 16'h0000;
   logic [15:0] want = 16'h0000;
   logic [15:0] hw_req;
   logic sw_src_req = 1'b0;
   logic sw_dst_req = 1'b0;
   logic [5:0] fifo_level = 6'h00;
   logic [5:0] burst_len = 6'h00;
   logic chunk_active = 1'b0;
   logic [9:0] dpip_boundary = 10'h000;
   logic [15:0] dpip_hole = 16'h0000;
   logic channel_active, src_master_sel, dst_master_sel, src_is_periph, dst_is_periph, dmac_flow_ctrl;
   logic src_req, dst_req, buffer_complete_flag, desc_wb_req, auto_disable, fifo_service;
   logic arb_hold, if_lock, bus_lock, desc_wb_done;
   logic [2:0] prot;
   logic [31:0] src_addr, dst_addr, rd, ctrla_cur;
   logic err;
   int fail_count = 0;
   int cmp_count = 0;

   always #4 pclk = ~pclk;

   dcc_periph_model #(.NPER(16)) partner (.pclk(pclk), .presetn(presetn), .want(want), .hw_req(hw_req));

   dcc_channel dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .write_protection_on(wp), .ch_start(ch_start), .start_saddr(32'h00001000),
      .start_daddr(32'h00002000), .start_ctrla(32'h22000000), .desc_load(desc_load),
      .desc_saddr(32'h00003000), .desc_daddr(32'h00004000), .desc_ctrla(desc_ctrla),
      .src_beat(src_beat), .dst_beat(dst_beat), .buffer_end(buffer_end), .chunk_active(chunk_active),
      .spip_boundary(spip_boundary), .spip_hole(spip_hole), .dpip_boundary(dpip_boundary),
      .dpip_hole(dpip_hole),
      .hw_req(hw_req), .sw_src_req(sw_src_req), .sw_dst_req(sw_dst_req), .fifo_level(fifo_level),
      .burst_len(burst_len), .channel_active(channel_active), .src_addr(src_addr), .dst_addr(dst_addr),
      .ctrla_cur(ctrla_cur), .src_master_sel(src_master_sel), .dst_master_sel(dst_master_sel),
      .src_is_periph(src_is_periph), .dst_is_periph(dst_is_periph), .dmac_flow_ctrl(dmac_flow_ctrl),
      .src_req(src_req), .dst_req(dst_req), .buffer_complete_flag(buffer_complete_flag),
      .desc_wb_req(desc_wb_req), .desc_wb_done(desc_wb_done), .auto_disable(auto_disable),
      .arb_hold(arb_hold), .if_lock(if_lock), .bus_lock(bus_lock), .bus_protection_attributes(prot),
      .fifo_service(fifo_service));

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         $display("unexpected %s expected %h seen %h", what, exp, got);
         fail_count++;
      end
   endtask : chk

   // One APB transfer; read data and error taken at the edge where pready is seen
   task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (n == 50)
         fail_count++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask : apb

   // One-cycle pulse of {start, fetch, source beat, destination beat, buffer end}
   task automatic ev(input logic [4:0] v);
      @(posedge pclk);
      {ch_start, desc_load, src_beat, dst_beat, buffer_end} <= v;
      @(posedge pclk);
      {ch_start, desc_load, src_beat, dst_beat, buffer_end} <= 5'h00;
      #1;
   endtask : ev

   task automatic hs(input logic [15:0] w, input logic s, input logic d);
      @(posedge pclk);
      want <= w;
      sw_src_req <= s;
      sw_dst_req <= d;
      repeat (2) @(posedge pclk);
      #1;
   endtask : hs

   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : tally_and_finish

   initial
   begin
      #40000;
      fail_count++;
      tally_and_finish();
   end

   initial
   begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `DCC_CTRLB_ADDR, 32'h00000000);
      chk("ctrlb reset", `DCC_CTRLB_RESET, rd);
      apb(1'b0, `DCC_CFG_ADDR, 32'h00000000);
      chk("cfg reset", `DCC_CFG_RESET, rd);
      apb(1'b0, 32'h00000000, 32'h00000000);
      chk("unmapped error", 32'h00000001, err);
      chk("unmapped data", 32'h00000000, rd);
      apb(1'b1, `DCC_CTRLB_ADDR, 32'hFFFFFFFF);
      apb(1'b0, `DCC_CTRLB_ADDR, 32'h00000000);
      chk("ctrlb mask", `DCC_CTRLB_MASK, rd);
      chk("src master", 32'h00000001, src_master_sel);
      chk("dst master", 32'h00000001, dst_master_sel);
      apb(1'b1, `DCC_CFG_ADDR, 32'hFFFFFFFF);
      apb(1'b0, `DCC_CFG_ADDR, 32'h00000000);
      chk("cfg mask", `DCC_CFG_MASK, rd);
      @(posedge pclk);
      wp <= 1'b1;
      apb(1'b1, `DCC_CTRLB_ADDR, 32'h00000000);
      apb(1'b1, `DCC_CFG_ADDR, 32'h00000000);
      apb(1'b0, `DCC_CTRLB_ADDR, 32'h00000000);
      chk("ctrlb protected", `DCC_CTRLB_MASK, rd);
      apb(1'b0, `DCC_CFG_ADDR, 32'h00000000);
      chk("cfg protected", `DCC_CFG_MASK, rd);
      @(posedge pclk);
      wp <= 1'b0;
      apb(1'b1, `DCC_CTRLB_ADDR, 32'h00000000);
      chk("src master low", 32'h00000000, src_master_sel);
      chk("dst master low", 32'h00000000, dst_master_sel);
      for (int d = 0; d < 4; d++)
      begin
         apb(1'b1, `DCC_CTRLB_ADDR, 32'(d) << 21);
         chk("src periph", d[1], src_is_periph);
         chk("dst periph", d[0], dst_is_periph);
         chk("flow ctrl", 32'h00000001, dmac_flow_ctrl);
      end
      apb(1'b1, `DCC_CFG_ADDR, 32'h00002253);
      hs(16'h0008, 1'b0, 1'b1);
      chk("src hw req", 32'h00000001, src_req);
      chk("dst hw req", 32'h00000000, dst_req);
      hs(16'h0020, 1'b1, 1'b0);
      chk("src hw idle", 32'h00000000, src_req);
      chk("dst hw set", 32'h00000001, dst_req);
      apb(1'b1, `DCC_CFG_ADDR, 32'h00000053);
      hs(16'hFFFF, 1'b1, 1'b0);
      chk("src sw req", 32'h00000001, src_req);
      chk("dst sw req", 32'h00000000, dst_req);
      apb(1'b1, `DCC_CFG_ADDR, 32'h00000000);
      for (int m = 0; m < 3; m++)
      begin
         apb(1'b1, `DCC_CTRLB_ADDR, (32'(m) << 24) | (32'(m) << 28));
         ev(5'h10);
         ev(5'h06);
         chk("src step", 32'h00001000 + (m == 0 ? `DCC_STEP_WORD : m == 1 ? -`DCC_STEP_WORD : 32'h0), src_addr);
         chk("dst step", 32'h00002000 + (m == 0 ? `DCC_STEP_WORD : m == 1 ? -`DCC_STEP_WORD : 32'h0), dst_addr);
      end
      apb(1'b1, `DCC_CTRLB_ADDR, 32'h00000100);
      @(posedge pclk);
      spip_boundary <= 10'h002;
      spip_hole <= 16'h0100;
      ev(5'h10);
      ev(5'h04);
      ev(5'h04);
      chk("src window", 32'h00001104, src_addr);
      for (int k = 0; k < 2; k++)
      begin
         apb(1'b1, `DCC_CTRLB_ADDR, 32'(k) * 32'h00110000);
         ev(5'h10);
         ev(5'h08);
         chk("src fetch", k ? 32'h00001000 : 32'h00003000, src_addr);
         chk("dst fetch", k ? 32'h00002000 : 32'h00004000, dst_addr);
      end
      for (int k = 0; k < 2; k++)
      begin
         apb(1'b1, `DCC_CTRLB_ADDR, 32'(k) << 30);
         ev(5'h10);
         ev(5'h01);
         chk("complete flag", k == 0, buffer_complete_flag);
         chk("write back", 32'h00000001, desc_wb_req);
      end
      for (int k = 0; k < 2; k++)
      begin
         apb(1'b1, `DCC_CFG_ADDR, 32'(k) << 16);
         @(posedge pclk);
         desc_ctrla <= 32'h80000000;
         ev(5'h10);
         chk("active", 32'h00000001, channel_active);
         ev(5'h08);
         chk("auto disable", k[0], auto_disable);
         @(posedge pclk);
         #1;
         chk("active after", !k[0], channel_active);
      end
      apb(1'b1, `DCC_CFG_ADDR, 32'h07300000);
      ev(5'h10);
      chk("if lock", 32'h00000001, if_lock);
      chk("bus lock", 32'h00000001, bus_lock);
      chk("protection", 32'h00000007, prot);
      for (int c = 0; c < 2; c++)
      begin
         @(posedge pclk);
         chunk_active <= c[0];
         #1;
         chk("arb chunk", c[0], arb_hold);
      end
      @(posedge pclk);
      chunk_active <= 1'b0;
      apb(1'b1, `DCC_CFG_ADDR, 32'h07700000);
      chk("arb buffer", 32'h00000001, arb_hold);
      apb(1'b1, `DCC_CFG_ADDR, 32'h00000000);
      chk("if lock off", 32'h00000000, if_lock);
      chk("arb off", 32'h00000000, arb_hold);
      apb(1'b1, `DCC_CTRLB_ADDR, 32'h00001000);
      @(posedge pclk);
      dpip_boundary <= 10'h001;
      dpip_hole <= 16'h0040;
      ev(5'h10);
      ev(5'h02);
      chk("dst window", 32'h00002040, dst_addr);
      apb(1'b1, `DCC_CFG_ADDR, 32'h00000100);
      for (int a = 0; a < 2; a++)
      begin
         apb(1'b1, `DCC_CTRLB_ADDR, 32'(a) << 31);
         ev(5'h10);
         ev(5'h06);
         ev(5'h01);
         chk("src replay", a ? 32'h00001000 : 32'h00001004, src_addr);
         chk("dst contiguous", 32'h00002004, dst_addr);
         chk("ctrla replay", 32'h22000000, ctrla_cur);
         chk("write back done", 32'h00000001, desc_wb_done);
      end
      apb(1'b1, `DCC_CFG_ADDR, 32'h00001000);
      ev(5'h10);
      ev(5'h06);
      ev(5'h01);
      chk("dst replay", 32'h00002000, dst_addr);
      chk("src contiguous", 32'h00001004, src_addr);
      @(posedge pclk);
      fifo_level <= 6'h04;
      burst_len <= 6'h08;
      for (int p = 0; p < 3; p++)
      begin
         apb(1'b1, `DCC_CFG_ADDR, 32'(p) << 28);
         chk("service", p == 2, fifo_service);
      end
      @(posedge pclk);
      fifo_level <= 6'h10;
      apb(1'b1, `DCC_CFG_ADDR, 32'h10000000);
      chk("service half", 32'h00000001, fifo_service);
      tally_and_finish();
   end
endmodule : dcc_channel_tb_top
